/* File: hw/timed_pattern_next_data.sv */
// Purpose: Staged pattern registers moved to port data on timer compare match
// Assumes: cmp_match pulses come from logic on pclk; hw_standby is an async pin
// Notes: Zero-wait APB slave; software standby needs no logic, state is kept
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module timed_pattern_next_data
  import timed_pattern_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NGROUP-1:0] cmp_match,
  input wire logic hw_standby,
  output logic [7:0] port_low_data,
  output logic [7:0] port_high_data
);
  logic [7:0] stg_low_r, stg_low_nxt;
  logic [7:0] stg_high_r, stg_high_nxt;
  logic [7:0] en_low_r, en_low_nxt;
  logic [7:0] en_high_r, en_high_nxt;
  logic [7:0] trig_r, trig_nxt;
  logic [7:0] port_low_r, port_low_nxt;
  logic [7:0] port_high_r, port_high_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic stby_meta_r, stby_r;
  logic [NGROUP-1:0] hit;
  logic [7:0] xfer_low, xfer_high;
  logic shared_low, shared_high;
  logic wr, setup;
  logic mapped;

  // Pin passes two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stby_meta_r <= 1'b0;
      stby_r <= 1'b0;
    end else begin
      stby_meta_r <= hw_standby;
      stby_r <= stby_meta_r;
    end
  end

  // Each group follows only the channel its select field names
  for (genvar g = 0; g < NGROUP; g++) begin : g_hit
    assign hit[g] = cmp_match[trig_r[g*SEL_W +: SEL_W]];
  end

  assign xfer_low = {{NIB_W{hit[1]}}, {NIB_W{hit[0]}}} & en_low_r;
  assign xfer_high = {{NIB_W{hit[3]}}, {NIB_W{hit[2]}}} & en_high_r;
  assign shared_low = trig_r[1:0] == trig_r[3:2];
  assign shared_high = trig_r[5:4] == trig_r[7:6];
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;

  always_comb begin
    mapped = 1'b1;
    rdata_nxt = rdata_r;
    case (paddr)
      byte_addr(IDX_TRIG): rdata_nxt = trig_r;
      byte_addr(IDX_EN_HIGH): rdata_nxt = en_high_r;
      byte_addr(IDX_EN_LOW): rdata_nxt = en_low_r;
      byte_addr(IDX_PORT_LOW): rdata_nxt = port_low_r;
      byte_addr(IDX_PORT_HIGH): rdata_nxt = port_high_r;
      byte_addr(IDX_STG_LOW_FIRST): begin
        rdata_nxt = shared_low ? stg_low_r : {stg_low_r[7:4], RSVD_NIB};
      end
      byte_addr(IDX_STG_LOW_SECOND): begin
        rdata_nxt = shared_low ? RSVD_BYTE : {RSVD_NIB, stg_low_r[3:0]};
      end
      byte_addr(IDX_STG_HIGH_FIRST): begin
        rdata_nxt = shared_high ? stg_high_r : {stg_high_r[7:4], RSVD_NIB};
      end
      byte_addr(IDX_STG_HIGH_SECOND): begin
        rdata_nxt = shared_high ? RSVD_BYTE : {RSVD_NIB, stg_high_r[3:0]};
      end
      default: begin
        mapped = 1'b0;
        rdata_nxt = STAGE_RST;
      end
    endcase
    err_nxt = err_r;
    // Read data is caught in the setup cycle so the access needs no wait
    if (!setup) begin
      rdata_nxt = rdata_r;
    end else begin
      err_nxt = ~mapped;
    end
  end

  always_comb begin
    stg_low_nxt = stg_low_r;
    stg_high_nxt = stg_high_r;
    en_low_nxt = en_low_r;
    en_high_nxt = en_high_r;
    trig_nxt = trig_r;
    port_low_nxt = port_low_r;
    port_high_nxt = port_high_r;
    if (wr) begin
      case (paddr)
        byte_addr(IDX_TRIG): trig_nxt = pwdata[7:0];
        byte_addr(IDX_EN_HIGH): en_high_nxt = pwdata[7:0];
        byte_addr(IDX_EN_LOW): en_low_nxt = pwdata[7:0];
        byte_addr(IDX_PORT_LOW): begin
          port_low_nxt = (port_low_r & en_low_r) | (pwdata[7:0] & ~en_low_r);
        end
        byte_addr(IDX_PORT_HIGH): begin
          port_high_nxt = (port_high_r & en_high_r) | (pwdata[7:0] & ~en_high_r);
        end
        byte_addr(IDX_STG_LOW_FIRST): begin
          if (shared_low) begin
            stg_low_nxt = pwdata[7:0];
          end else begin
            stg_low_nxt[7:4] = pwdata[7:4];
          end
        end
        byte_addr(IDX_STG_LOW_SECOND): begin
          if (!shared_low) begin
            stg_low_nxt[3:0] = pwdata[3:0];
          end
        end
        byte_addr(IDX_STG_HIGH_FIRST): begin
          if (shared_high) begin
            stg_high_nxt = pwdata[7:0];
          end else begin
            stg_high_nxt[7:4] = pwdata[7:4];
          end
        end
        byte_addr(IDX_STG_HIGH_SECOND): begin
          if (!shared_high) begin
            stg_high_nxt[3:0] = pwdata[3:0];
          end
        end
        default: begin
          trig_nxt = trig_r;
        end
      endcase
    end
    // Transfer uses the old stage, so a same-cycle write lands next match
    port_low_nxt = (port_low_nxt & ~xfer_low) | (stg_low_r & xfer_low);
    port_high_nxt = (port_high_nxt & ~xfer_high) | (stg_high_r & xfer_high);
    if (stby_r) begin
      stg_low_nxt = STAGE_RST;
      stg_high_nxt = STAGE_RST;
      en_low_nxt = EN_RST;
      en_high_nxt = EN_RST;
      trig_nxt = TRIG_RST;
      port_low_nxt = PORT_RST;
      port_high_nxt = PORT_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_low_r <= STAGE_RST;
      stg_high_r <= STAGE_RST;
      en_low_r <= EN_RST;
      en_high_r <= EN_RST;
      trig_r <= TRIG_RST;
      port_low_r <= PORT_RST;
      port_high_r <= PORT_RST;
      rdata_r <= STAGE_RST;
      err_r <= 1'b0;
    end else begin
      stg_low_r <= stg_low_nxt;
      stg_high_r <= stg_high_nxt;
      en_low_r <= en_low_nxt;
      en_high_r <= en_high_nxt;
      trig_r <= trig_nxt;
      port_low_r <= port_low_nxt;
      port_high_r <= port_high_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = {RDATA_PAD, rdata_r};
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_r;
  assign port_low_data = port_low_r;
  assign port_high_data = port_high_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence low_split_write_s;
    wr && !shared_low && paddr == byte_addr(IDX_STG_LOW_FIRST) && !stby_r;
  endsequence

  sequence high_split_write_s;
    wr && !shared_high && paddr == byte_addr(IDX_STG_HIGH_FIRST) && !stby_r;
  endsequence

  // Three samples of the pin cover both sync stages
  sequence stby_pin_s;
    hw_standby [*3];
  endsequence

  stage_low_clear_a: assert property (stby_r |=> stg_low_r == STAGE_RST)
    else $error("low stage not cleared in standby");
  stage_high_clear_a: assert property (stby_r |=> stg_high_r == STAGE_RST)
    else $error("high stage not cleared in standby");
  enable_low_clear_a: assert property (stby_r |=> en_low_r == EN_RST)
    else $error("low enable not cleared in standby");
  trig_clear_a: assert property (stby_r |=> trig_r == TRIG_RST)
    else $error("trigger select not reset in standby");
  standby_pin_a: assert property (
      stby_pin_s |=> stg_low_r == STAGE_RST && stg_high_r == STAGE_RST)
    else $error("stage not cleared after standby pin");
  low_copy_a: assert property (
      hit[0] && en_low_r[0] && !stby_r |=> port_low_r[0] == $past(stg_low_r[0]))
    else $error("enabled low bit not copied on match");
  low_group_copy_a: assert property (
      hit[1] && en_low_r[7] && !stby_r |=> port_low_r[7] == $past(stg_low_r[7]))
    else $error("low group one bit not copied on match");
  low_block_a: assert property (
      !en_low_r[0] && !stby_r && !wr |=> $stable(port_low_r[0]))
    else $error("disabled low bit changed");
  high_copy_a: assert property (
      hit[2] && en_high_r[0] && !stby_r |=> port_high_r[0] == $past(stg_high_r[0]))
    else $error("enabled high bit not copied on match");
  high_group_copy_a: assert property (
      hit[3] && en_high_r[7] && !stby_r |=> port_high_r[7] == $past(stg_high_r[7]))
    else $error("high group three bit not copied on match");
  high_block_a: assert property (
      !en_high_r[0] && !stby_r && !wr |=> $stable(port_high_r[0]))
    else $error("disabled high bit changed");
  // Only enabled bits are checked; disabled bits take the write
  port_readonly_a: assert property (
      wr && paddr == byte_addr(IDX_PORT_LOW) && hit[1:0] == 2'b00 && !stby_r
      |=> (port_low_r & $past(en_low_r)) == ($past(port_low_r) & $past(en_low_r)))
    else $error("enabled port bits took a software write");
  group_isolate_a: assert property (
      !hit[1] && !wr && !stby_r |=> $stable(port_low_r[7:4]))
    else $error("group one bits changed without its match");
  high_isolate_a: assert property (
      !hit[3] && !wr && !stby_r |=> $stable(port_high_r[7:4]))
    else $error("group three bits changed without its match");
  low_shared_write_a: assert property (
      wr && shared_low && paddr == byte_addr(IDX_STG_LOW_FIRST) && !stby_r
      |=> stg_low_r == $past(pwdata[7:0]))
    else $error("shared low stage write not taken whole");
  low_second_ignore_a: assert property (
      wr && shared_low && paddr == byte_addr(IDX_STG_LOW_SECOND) && !stby_r
      |=> $stable(stg_low_r))
    else $error("reserved low address took a write");
  low_split_second_a: assert property (
      wr && !shared_low && paddr == byte_addr(IDX_STG_LOW_SECOND) && !stby_r
      |=> stg_low_r == {$past(stg_low_r[7:4]), $past(pwdata[3:0])})
    else $error("split low second address wrote wrong nibble");
  split_nibble_a: assert property (
      low_split_write_s |=> stg_low_r[3:0] == $past(stg_low_r[3:0]))
    else $error("reserved nibble of first low address was written");
  low_split_read_a: assert property (
      setup && !shared_low && paddr == byte_addr(IDX_STG_LOW_SECOND)
      |=> prdata[7:4] == RSVD_NIB)
    else $error("reserved nibble of second low address did not read ones");
  reserved_read_a: assert property (
      setup && shared_low && paddr == byte_addr(IDX_STG_LOW_SECOND)
      |=> prdata[7:0] == RSVD_BYTE)
    else $error("reserved low address did not read ones");
  high_shared_write_a: assert property (
      wr && shared_high && paddr == byte_addr(IDX_STG_HIGH_FIRST) && !stby_r
      |=> stg_high_r == $past(pwdata[7:0]))
    else $error("shared high stage write not taken whole");
  high_second_ignore_a: assert property (
      wr && shared_high && paddr == byte_addr(IDX_STG_HIGH_SECOND) && !stby_r
      |=> $stable(stg_high_r))
    else $error("reserved high address took a write");
  high_split_second_a: assert property (
      wr && !shared_high && paddr == byte_addr(IDX_STG_HIGH_SECOND) && !stby_r
      |=> stg_high_r == {$past(stg_high_r[7:4]), $past(pwdata[3:0])})
    else $error("split high second address wrote wrong nibble");
  high_split_nibble_a: assert property (
      high_split_write_s |=> stg_high_r[3:0] == $past(stg_high_r[3:0]))
    else $error("reserved nibble of first high address was written");
  high_split_read_a: assert property (
      setup && !shared_high && paddr == byte_addr(IDX_STG_HIGH_FIRST)
      |=> prdata[3:0] == RSVD_NIB)
    else $error("reserved nibble of first high address did not read ones");
  trig_write_a: assert property (
      wr && paddr == byte_addr(IDX_TRIG) && !stby_r |=> trig_r == $past(pwdata[7:0]))
    else $error("trigger select write not taken");
endmodule
`default_nettype wire

/* File: hw/timed_pattern_pkg.sv */
// Purpose: Constants for the timed pattern next-data block
// Assumes: APB word addressing, byte address is four times the index
// Notes: Indices are the printed register offsets
`default_nettype none
package timed_pattern_pkg;
  localparam int ADDR_W = 18;
  localparam int NGROUP = 4;
  localparam int SEL_W = 2;
  localparam int NIB_W = 4;
  localparam logic [15:0] IDX_TRIG = 16'hffa1;
  localparam logic [15:0] IDX_EN_HIGH = 16'hffa2;
  localparam logic [15:0] IDX_EN_LOW = 16'hffa3;
  localparam logic [15:0] IDX_STG_HIGH_FIRST = 16'hffa4;
  localparam logic [15:0] IDX_STG_LOW_FIRST = 16'hffa5;
  localparam logic [15:0] IDX_STG_HIGH_SECOND = 16'hffa6;
  localparam logic [15:0] IDX_STG_LOW_SECOND = 16'hffa7;
  localparam logic [15:0] IDX_PORT_LOW = 16'hffd3;
  localparam logic [15:0] IDX_PORT_HIGH = 16'hffd6;
  localparam logic [7:0] STAGE_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'hff;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] RSVD_BYTE = 8'hff;
  localparam logic [3:0] RSVD_NIB = 4'hf;
  localparam logic [23:0] RDATA_PAD = 24'h000000;
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction
endpackage
`default_nettype wire

/* File: verif/timed_pattern_next_data_bench.sv */
// Purpose: Self-checking bench for the staged pattern block
// Assumes: Byte address is four times the index
// Notes: Waits for pready, never assumes zero wait
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module timed_pattern_next_data_bench;
  import timed_pattern_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby, err_v;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] ev_req, cmp_match;
  logic [7:0] port_low_data, port_high_data, rd_v;
  int bad_count = 0;
  int samples_checked = 0;
  timed_pattern_next_data dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_match(cmp_match),
    .hw_standby(hw_standby), .port_low_data(port_low_data),
    .port_high_data(port_high_data));
  timer_model timer_u (.pclk(pclk), .presetn(presetn), .event_req(ev_req),
    .cmp_match(cmp_match));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until an edge sees pready high; the answer is taken there
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_v = prdata[7:0];
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    `CHK($sformatf("rd %h", idx), exp, rd_v)
  endtask
  task automatic fire(input logic [1:0] ch);
    @(posedge pclk);
    ev_req <= 4'h1 << ch;
    @(posedge pclk);
    ev_req <= 4'h0;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    close_out;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ev_req = 4'h0;
    hw_standby = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_TRIG, 8'hff);
    rd(IDX_EN_LOW, 8'h00);
    rd(IDX_STG_LOW_FIRST, 8'h00);
    rd(IDX_STG_HIGH_FIRST, 8'h00);
    xfer(1'b1, IDX_STG_LOW_FIRST, 8'ha5);
    xfer(1'b1, IDX_STG_LOW_SECOND, 8'h00);
    rd(IDX_STG_LOW_FIRST, 8'ha5);
    rd(IDX_STG_LOW_SECOND, 8'hff);
    xfer(1'b1, IDX_STG_HIGH_FIRST, 8'h3c);
    xfer(1'b1, IDX_STG_HIGH_SECOND, 8'h00);
    rd(IDX_STG_HIGH_FIRST, 8'h3c);
    rd(IDX_STG_HIGH_SECOND, 8'hff);
    xfer(1'b1, IDX_EN_LOW, 8'h0f);
    xfer(1'b1, IDX_EN_HIGH, 8'hff);
    fire(2'd3);
    `CHK("port_low", 8'h05, port_low_data)
    `CHK("port_high", 8'h3c, port_high_data)
    xfer(1'b1, IDX_PORT_LOW, 8'hff);
    rd(IDX_PORT_LOW, 8'hf5);
    xfer(1'b1, IDX_EN_LOW, 8'h00);
    fire(2'd3);
    `CHK("port_low", 8'hf5, port_low_data)
    xfer(1'b1, IDX_EN_LOW, 8'hff);
    xfer(1'b1, IDX_TRIG, 8'he4);
    xfer(1'b1, IDX_STG_LOW_FIRST, 8'h6a);
    xfer(1'b1, IDX_STG_LOW_SECOND, 8'h5c);
    rd(IDX_STG_LOW_FIRST, 8'h6f);
    rd(IDX_STG_LOW_SECOND, 8'hfc);
    xfer(1'b1, IDX_STG_LOW_FIRST, 8'h6f);
    rd(IDX_STG_LOW_SECOND, 8'hfc);
    xfer(1'b1, IDX_STG_HIGH_FIRST, 8'h93);
    xfer(1'b1, IDX_STG_HIGH_SECOND, 8'ha7);
    rd(IDX_STG_HIGH_FIRST, 8'h9f);
    rd(IDX_STG_HIGH_SECOND, 8'hf7);
    fire(2'd0);
    `CHK("port_low", 8'hfc, port_low_data)
    fire(2'd1);
    `CHK("port_low", 8'h6c, port_low_data)
    fire(2'd2);
    `CHK("port_high", 8'h37, port_high_data)
    fire(2'd3);
    `CHK("port_high", 8'h97, port_high_data)
    rd(16'hffb0, 8'h00);
    `CHK("pslverr", 1'b1, err_v)
    hw_standby <= 1'b1;
    repeat (5) @(posedge pclk);
    hw_standby <= 1'b0;
    rd(IDX_TRIG, 8'hff);
    rd(IDX_STG_LOW_FIRST, 8'h00);
    rd(IDX_STG_HIGH_FIRST, 8'h00);
    rd(IDX_EN_LOW, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire

/* File: verif/timer_model.sv */
// Purpose: Timer unit stand-in giving compare-match pulses
// Assumes: Same clock as the pattern block
// Notes: One-cycle pulse per request, low between events
`timescale 1ns/1ps
`default_nettype none
module timer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] event_req,
  output logic [3:0] cmp_match
);
  // Registered so pulses change just after an edge, as a real timer flag does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_match <= 4'h0;
    end else begin
      cmp_match <= event_req;
    end
  end
endmodule
`default_nettype wire
